// ==== sorc_consts.vh ====
// Constants for the safety output restart control block
`ifndef SORC_CONSTS_VH
`define SORC_CONSTS_VH

// Register byte addresses
`define SORC_ADDR_CTRL 12'h000
`define SORC_ADDR_MODE 12'h004
`define SORC_ADDR_IND 12'h008
`define SORC_ADDR_STATUS 12'h00c
`define SORC_ADDR_TEST 12'h010
`define SORC_ADDR_FAULT 12'h014

// Control register fields
`define SORC_CTRL_GRP_LSB 0
`define SORC_CTRL_TEST_EN_BIT 2
`define SORC_CTRL_RESET 32'h0000_0000

// Mode register: 2 bits of restart mode per group, then check enables
`define SORC_MODE_CHK_LSB 8
`define SORC_MODE_RESET 32'h0000_0000

// Restart modes
`define SORC_RST_AUTO 2'h0
`define SORC_RST_MANUAL 2'h1
`define SORC_RST_MONITORED 2'h2

// Output groupings
`define SORC_GRP_FOUR_SINGLE 2'h0
`define SORC_GRP_TWO_DUAL 2'h1
`define SORC_GRP_MIXED 2'h2

// Indicator source kinds, index in bits 2:0, kind in bits 5:4
`define SORC_IND_INPUT 2'h0
`define SORC_IND_OUTPUT 2'h1
`define SORC_IND_NODE 2'h2
`define SORC_IND_KIND_LSB 4
`define SORC_IND_RESET 32'h0000_0000

// Timing
`define SORC_CLK_PERIOD_NS 4
`define SORC_FILT_TIME_NS 1000
`define SORC_FILT_CYCLES \
  ((`SORC_FILT_TIME_NS + `SORC_CLK_PERIOD_NS - 1) / `SORC_CLK_PERIOD_NS)
`define SORC_EDM_TIME_NS 12000
`define SORC_EDM_CYCLES (`SORC_EDM_TIME_NS / `SORC_CLK_PERIOD_NS)
`define SORC_TEST_PERIOD_NS 10000
`define SORC_TEST_PERIOD_CYCLES \
  (`SORC_TEST_PERIOD_NS / `SORC_CLK_PERIOD_NS)
`define SORC_TEST_PULSE_NS 200
`define SORC_TEST_PULSE_CYCLES \
  ((`SORC_TEST_PULSE_NS + `SORC_CLK_PERIOD_NS - 1) / `SORC_CLK_PERIOD_NS)

`endif

// ==== sorc_restart_chan.v ====
// One restart/feedback channel: filter, edge detection, switch-on state
`timescale 1ns/1ps
`default_nettype none
`include "sorc_consts.vh"

module sorc_restart_chan #(
  parameter FILT_CYCLES = `SORC_FILT_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Restart/feedback pin and configuration
  input wire raw_in,
  input wire [1:0] mode,
  input wire check_en,
  // Qualifiers
  input wire demand,
  input wire run_ok,
  input wire kill,
  // Results
  output reg filt_level,
  output reg switch_on
);

  reg sync_a;
  reg sync_b;
  reg [15:0] stable_cnt;
  reg filt_prev;
  reg high_seen;
  wire rise;
  wire fall;
  wire trigger;
  wire drop;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      stable_cnt <= 16'h0000;
      filt_level <= 1'b0;
      filt_prev <= 1'b0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      filt_prev <= filt_level;
      if (sync_b == filt_level) begin
        stable_cnt <= 16'h0000;
      end else if (stable_cnt == FILT_CYCLES[15:0] - 16'h0001) begin
        stable_cnt <= 16'h0000;
        filt_level <= sync_b;
      end else begin
        stable_cnt <= stable_cnt + 16'h0001;
      end
    end
  end

  assign rise = filt_level & ~filt_prev;
  assign fall = ~filt_level & filt_prev;

  // remember the high phase of a pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_seen <= 1'b0;
    end else if (switch_on) begin
      high_seen <= 1'b0;
    end else if (rise) begin
      high_seen <= 1'b1;
    end else if (fall) begin
      high_seen <= 1'b0;
    end
  end

  assign trigger = (mode == `SORC_RST_AUTO) ? filt_level :
                   (mode == `SORC_RST_MANUAL) ? rise :
                   (mode == `SORC_RST_MONITORED) ? (fall & high_seen) :
                   1'b0;

  // auto without check follows the level
  assign drop = ~demand | ~run_ok | kill |
                ((mode == `SORC_RST_AUTO) & ~check_en & ~filt_level);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_on <= 1'b0;
    end else if (drop) begin
      switch_on <= 1'b0;
    end else if (!switch_on && trigger) begin
      switch_on <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== sorc_top.v ====
// Safety output restart control with APB register access
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sorc_consts.vh"

module sorc_top #(
  parameter HAS_RUN_PERMIT = 1,
  parameter FILT_CYCLES = `SORC_FILT_CYCLES,
  parameter EDM_CYCLES = `SORC_EDM_CYCLES,
  parameter TEST_PERIOD_CYCLES = `SORC_TEST_PERIOD_CYCLES,
  parameter TEST_PULSE_CYCLES = `SORC_TEST_PULSE_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // System run permits
  input wire system_run_permit_a,
  input wire system_run_permit_b,
  // Address straps
  input wire address_strap_low,
  input wire address_strap_high,
  // Restart/feedback inputs, one per group
  input wire [3:0] restart_feedback,
  // Logic demand per group from the configured logic
  input wire [3:0] logic_demand,
  // Indicator sources
  input wire [7:0] monitored_inputs,
  input wire [7:0] logic_nodes,
  // Outputs
  output reg [3:0] safety_switched_output,
  output reg indicator_output,
  output reg [1:0] test_pulse_output,
  output reg [1:0] node_address,
  output reg system_active
);

  reg [31:0] ctrl;
  reg [31:0] mode_reg;
  reg [31:0] ind_sel;
  reg [31:0] test_period;
  reg strap_taken;
  reg [31:0] test_cnt;
  reg [31:0] next_prdata;
  reg addr_ok;
  reg [1:0] grp_of [0:3];
  reg next_indicator;

  wire setup;
  wire wr_access;
  wire run_ok;
  wire [1:0] grouping;
  wire [3:0] check_en;
  wire [3:0] filt_level;
  wire [3:0] switch_on;
  wire [3:0] edm_timeout;
  wire [3:0] edm_fault;
  wire [3:0] fault_clear;
  wire [3:0] next_outputs;
  wire wr_ctrl;
  wire wr_mode;
  wire wr_ind;
  wire wr_test;
  wire wr_fault;
  wire test_en;
  wire [2:0] ind_index;
  wire [1:0] ind_kind;

  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  assign grouping = ctrl[`SORC_CTRL_GRP_LSB +: 2];
  assign test_en = ctrl[`SORC_CTRL_TEST_EN_BIT];
  assign check_en = mode_reg[`SORC_MODE_CHK_LSB +: 4];
  assign ind_index = ind_sel[2:0];
  assign ind_kind = ind_sel[`SORC_IND_KIND_LSB +: 2];
  assign fault_clear = wr_fault ? pwdata[3:0] : 4'h0;

  // Write strobes, one per writable register; STATUS is read only
  assign wr_ctrl = wr_access & (paddr == `SORC_ADDR_CTRL);
  assign wr_mode = wr_access & (paddr == `SORC_ADDR_MODE);
  assign wr_ind = wr_access & (paddr == `SORC_ADDR_IND);
  assign wr_test = wr_access & (paddr == `SORC_ADDR_TEST);
  assign wr_fault = wr_access & (paddr == `SORC_ADDR_FAULT);

  generate
    if (HAS_RUN_PERMIT != 0) begin : g_permit
      assign run_ok = system_run_permit_a & system_run_permit_b;
    end else begin : g_always
      assign run_ok = 1'b1;
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_active <= 1'b0;
    end else begin
      system_active <= run_ok;
    end
  end

  // straps caught once after reset release
  // A strap wire that works loose cannot move the address in operation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_address <= 2'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      node_address <= {address_strap_high, address_strap_low};
      strap_taken <= 1'b1;
    end
  end

  // Address decode
  always @* begin
    addr_ok = 1'b1;
    if (paddr == `SORC_ADDR_CTRL) begin
      next_prdata = ctrl;
    end else if (paddr == `SORC_ADDR_MODE) begin
      next_prdata = mode_reg;
    end else if (paddr == `SORC_ADDR_IND) begin
      next_prdata = ind_sel;
    end else if (paddr == `SORC_ADDR_STATUS) begin
      next_prdata = {16'h0000, switch_on, filt_level,
                     safety_switched_output, 1'b0, node_address,
                     system_active};
    end else if (paddr == `SORC_ADDR_TEST) begin
      next_prdata = test_period;
    end else if (paddr == `SORC_ADDR_FAULT) begin
      next_prdata = {28'h0000000, edm_fault};
    end else begin
      next_prdata = 32'h0000_0000;
      addr_ok = 1'b0;
    end
  end

  // Read data is captured in the setup cycle
  // Status may move before the access; the setup snapshot is returned
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Register writes take effect at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SORC_CTRL_RESET;
      mode_reg <= `SORC_MODE_RESET;
      ind_sel <= `SORC_IND_RESET;
      test_period <= TEST_PERIOD_CYCLES;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {29'h00000000, pwdata[2:0]};
      end else if (wr_mode) begin
        mode_reg <= {20'h00000, pwdata[11:0]};
      end else if (wr_ind) begin
        ind_sel <= {26'h0000000, pwdata[5:4], 1'b0, pwdata[2:0]};
      end else if (wr_test) begin
        // A period no longer than the pulse would never end the pulse
        if (pwdata > {1'b0, TEST_PULSE_CYCLES[30:0]}) begin
          test_period <= pwdata;
        end
      end
    end
  end

  // group index of each output for the chosen grouping
  // Group 3 drives no output in the two dual groupings
  always @* begin
    grp_of[0] = 2'h0;
    grp_of[1] = 2'h1;
    grp_of[2] = 2'h2;
    grp_of[3] = 2'h3;
    case (grouping)
      `SORC_GRP_TWO_DUAL: begin
        grp_of[1] = 2'h0;
        grp_of[2] = 2'h1;
        grp_of[3] = 2'h1;
      end
      `SORC_GRP_MIXED: begin
        grp_of[1] = 2'h0;
        grp_of[2] = 2'h1;
        grp_of[3] = 2'h2;
      end
      default: begin
        grp_of[0] = 2'h0;
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      sorc_restart_chan #(
        .FILT_CYCLES(FILT_CYCLES)
      ) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .raw_in(restart_feedback[gi]),
        .mode(mode_reg[2*gi +: 2]),
        .check_en(check_en[gi]),
        .demand(logic_demand[gi]),
        .run_ok(run_ok),
        .kill(edm_fault[gi]),
        .filt_level(filt_level[gi]),
        .switch_on(switch_on[gi])
      );

      // contactors must close once the group is on
      // The count stops at the limit so it cannot wrap back to zero
      reg [31:0] edm_cnt;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          edm_cnt <= 32'h0000_0000;
        end else if (switch_on[gi] && check_en[gi] && filt_level[gi]) begin
          if (!edm_timeout[gi]) begin
            edm_cnt <= edm_cnt + 32'h0000_0001;
          end
        end else begin
          edm_cnt <= 32'h0000_0000;
        end
      end
      assign edm_timeout[gi] = (edm_cnt >= EDM_CYCLES - 1);

      // fault is sticky; a new timeout wins over a clear
      reg fault_bit;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fault_bit <= 1'b0;
        end else if (edm_timeout[gi] && switch_on[gi]) begin
          fault_bit <= 1'b1;
        end else if (fault_clear[gi]) begin
          fault_bit <= 1'b0;
        end
      end
      assign edm_fault[gi] = fault_bit;
    end
  endgenerate

  // outputs follow their group's switch state
  // Gating on run_ok here as well means a permit loss reaches the pins
  // at the next edge, without waiting for the channels to drop
  genvar oi;
  generate
    for (oi = 0; oi < 4; oi = oi + 1) begin : g_out
      assign next_outputs[oi] = switch_on[grp_of[oi]] & run_ok;
    end
  endgenerate

  // outputs dropped at once when permits fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_switched_output <= 4'h0;
    end else begin
      safety_switched_output <= next_outputs;
    end
  end

  always @* begin
    case (ind_kind)
      `SORC_IND_INPUT: begin
        next_indicator = monitored_inputs[ind_index];
      end
      `SORC_IND_OUTPUT: begin
        next_indicator = safety_switched_output[ind_index[1:0]];
      end
      `SORC_IND_NODE: begin
        next_indicator = logic_nodes[ind_index];
      end
      default: begin
        next_indicator = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_output <= 1'b0;
    end else begin
      indicator_output <= next_indicator;
    end
  end

  // Test pulse sources: high, with a short low pulse each period,
  // the two sources staggered by half a period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_cnt <= 32'h0000_0000;
    end else if (!test_en || test_cnt >= test_period - 32'h0000_0001) begin
      test_cnt <= 32'h0000_0000;
    end else begin
      test_cnt <= test_cnt + 32'h0000_0001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_pulse_output <= 2'h0;
    end else if (!test_en) begin
      test_pulse_output <= 2'h3;
    end else begin
      test_pulse_output[0] <= (test_cnt >= TEST_PULSE_CYCLES);
      test_pulse_output[1] <=
        ~((test_cnt >= {1'b0, test_period[31:1]}) &&
          (test_cnt < {1'b0, test_period[31:1]} + TEST_PULSE_CYCLES));
    end
  end

endmodule
`default_nettype wire

// ==== sorc_checker.sv ====
// Port checker for the restart control block
`timescale 1ns/1ps
`default_nettype none
`include "sorc_consts.vh"
module sorc_checker #(
  parameter FILT_CYCLES = `SORC_FILT_CYCLES,
  parameter EDM_CYCLES = `SORC_EDM_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB writes
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Pins
  input wire logic system_run_permit_a,
  input wire logic system_run_permit_b,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  input wire logic [3:0] restart_feedback,
  input wire logic [3:0] logic_demand,
  input wire logic [3:0] safety_switched_output,
  input wire logic [1:0] node_address,
  input wire logic system_active
);
  logic [1:0] grp, m0;
  logic chk3, long0;
  logic [7:0] hi, lo, onhi;
  wire wr = psel && penable && pwrite;
  wire p0 = restart_feedback[0];
  wire [3:0] so = safety_switched_output;
  // Shadow of the configuration and pin run lengths
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp <= 2'h0;
      m0 <= 2'h0;
      chk3 <= 1'b0;
      long0 <= 1'b0;
      hi <= 8'h00;
      lo <= 8'h00;
      onhi <= 8'h00;
    end else begin
      if (wr && paddr == `SORC_ADDR_CTRL) grp <= pwdata[1:0];
      if (wr && paddr == `SORC_ADDR_MODE) m0 <= pwdata[1:0];
      if (wr && paddr == `SORC_ADDR_MODE) chk3 <= pwdata[11];
      hi <= !p0 ? 8'h00 : (hi == 8'hff ? hi : hi + 8'h01);
      lo <= p0 ? 8'h00 : (lo == 8'hff ? lo : lo + 8'h01);
      long0 <= long0 || hi >= FILT_CYCLES;
      onhi <= (chk3 && grp == 2'h0 && so[3] && restart_feedback[3]) ?
        onhi + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_start;
    $rose(so[0]);
  endsequence
  AST_PERMIT_DROP: assert property (
    !(system_run_permit_a && system_run_permit_b) |=> so == 4'h0)
    else $error("output on after permit loss");
  AST_RUN_ONLY: assert property (
    so != 4'h0 |-> system_active) else $error("output on while inactive");
  AST_NODE_ADDR: assert property (
    presetn && !$past(presetn) |=>
    node_address == $past({address_strap_high, address_strap_low}))
    else $error("node address wrong");
  AST_DEMAND: assert property (
    s_start |-> $past(logic_demand[0], 2)) else $error("start without demand");
  AST_FILTER: assert property (
    s_start |-> long0) else $error("start on a glitch");
  AST_AUTO_LOW: assert property (
    m0 == `SORC_RST_AUTO && lo > FILT_CYCLES + 6 |-> !so[0])
    else $error("auto output on with input low");
  AST_GROUP: assert property (
    (grp == 2'h1 || grp == 2'h2) && $stable(grp) |-> so[1] == so[0])
    else $error("dual channel outputs differ");
  AST_CONTACTOR: assert property (
    onhi < EDM_CYCLES + FILT_CYCLES + 8) else $error("feedback fault missed");
endmodule
`default_nettype wire

// ==== sorc_field_model.sv ====
// Restart switches and a contactor pair on the feedback inputs
`timescale 1ns/1ps
`default_nettype none
module sorc_field_model (
  // Clock
  input wire logic pclk,
  // Bench commands
  input wire logic [3:0] switch_closed,
  input wire logic coil_open,
  // Coil drive
  input wire logic [3:0] safety_switched_output,
  // Feedback inputs of the device
  output logic [3:0] restart_feedback
);
  logic [1:0] pull = 2'h0;
  always @(posedge pclk) begin
    pull <= {pull[0], safety_switched_output[3] && !coil_open};
  end
  assign restart_feedback = {switch_closed[3] && !pull[1], switch_closed[2:0]};
endmodule
`default_nettype wire

// ==== safety_output_restart_control_tb_top.sv ====
// Self-checking bench for the restart control block
`timescale 1ns/1ps
`default_nettype none
`include "sorc_consts.vh"
module safety_output_restart_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pa, pb, sl, sh, nopull;
  logic pready, pslverr, ind, sa, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, s;
  logic [3:0] rf, ld, sw, sso;
  logic [7:0] mi, ln;
  logic [1:0] na, k, tp;
  logic [31:0] seed = 32'h0000fd91;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  int i, n0, n1;
  always #2 pclk = ~pclk;
  sorc_top #(.FILT_CYCLES(4), .EDM_CYCLES(20), .TEST_PERIOD_CYCLES(40),
    .TEST_PULSE_CYCLES(3)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .system_run_permit_a(pa), .system_run_permit_b(pb),
    .address_strap_low(sl), .address_strap_high(sh), .restart_feedback(rf),
    .logic_demand(ld), .monitored_inputs(mi), .logic_nodes(ln),
    .safety_switched_output(sso), .indicator_output(ind),
    .test_pulse_output(tp), .node_address(na), .system_active(sa));
  sorc_field_model field (.pclk, .switch_closed(sw), .coil_open(nopull),
    .safety_switched_output(sso), .restart_feedback(rf));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic ind_exp(input logic [1:0] kd,
    input logic [2:0] x, input logic [3:0] o);
    case (kd)
      2'h1: return o[x[1:0]];
      2'h2: return ln[x];
      2'h0: return mi[x];
      default: return 1'b0;
    endcase
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic pins(input logic [3:0] v);
    @(posedge pclk);
    sw <= v;
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, nopull} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {pa, pb} = 2'h3;
    s = xs();
    // one strap setting per module, four addresses only
    {sh, sl} = s[1:0];
    // proximity pair on mi[1:0] never both low
    {sw, ld, mi, ln} = {4'h0, 4'hf, s[15:10], 2'h3, s[23:16]};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk(na, {sh, sl});
    apb(1'b0, `SORC_ADDR_STATUS, 32'h0);
    chk(r[2:1], {sh, sl});
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b0, `SORC_ADDR_TEST, 32'h0);
    chk(r, 32'h0000_0028);
    apb(1'b0, 12'h03c, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(1'b1, `SORC_ADDR_MODE, 32'h0000_0824);
    done("registers");
    pins(4'h1);
    repeat (2) @(posedge pclk);
    pins(4'h0);
    cyc(12);
    chk(sso, 4'h0);
    pins(4'h1);
    cyc(12);
    chk(sso, 4'h1);
    pins(4'h3);
    cyc(12);
    chk(sso, 4'h3);
    pins(4'h7);
    cyc(12);
    chk(sso, 4'h3);
    pins(4'h3);
    cyc(12);
    chk(sso, 4'h7);
    pins(4'h2);
    cyc(12);
    chk(sso, 4'h6);
    done("restart");
    pins(4'ha);
    cyc(40);
    chk(sso, 4'he);
    @(posedge pclk);
    nopull <= 1'b1;
    ld <= 4'h7;
    cyc(6);
    @(posedge pclk);
    ld <= 4'hf;
    cyc(12);
    chk(sso[3], 1'b1);
    cyc(24);
    chk(sso[3], 1'b0);
    apb(1'b0, `SORC_ADDR_FAULT, 32'h0);
    chk(r[3:0], 4'h8);
    @(posedge pclk);
    nopull <= 1'b0;
    apb(1'b1, `SORC_ADDR_FAULT, 32'h8);
    apb(1'b0, `SORC_ADDR_FAULT, 32'h0);
    chk(r[3:0], 4'h0);
    done("contactor");
    @(posedge pclk);
    pa <= 1'b0;
    cyc(2);
    chk(sso, 4'h0);
    chk(sa, 1'b0);
    @(posedge pclk);
    pa <= 1'b1;
    cyc(14);
    chk(sa, 1'b1);
    chk(sso, 4'h8);
    pins(4'hb);
    apb(1'b1, `SORC_ADDR_CTRL, {30'h0, `SORC_GRP_TWO_DUAL});
    cyc(12);
    chk(sso, 4'h3);
    apb(1'b1, `SORC_ADDR_CTRL, {30'h0, `SORC_GRP_MIXED});
    cyc(2);
    chk(sso, 4'h3);
    done("grouping");
    for (i = 0; i < 8; i++) begin
      s = xs();
      k = i[1:0];
      @(posedge pclk);
      {mi, ln} <= {s[15:10], s[9] | ~s[8], s[8], s[7:0]};
      apb(1'b1, `SORC_ADDR_IND, {26'h0, k, 1'b0, s[18:16]});
      cyc(3);
      chk(ind, ind_exp(k, s[18:16], 4'h3));
    end
    done("indicator");
    apb(1'b1, `SORC_ADDR_CTRL, 32'h0000_0004);
    cyc(4);
    n0 = 0;
    n1 = 0;
    repeat (40) begin
      mi[5:2] <= {4{tp[0]}};
      n0 += !tp[0];
      n1 += !tp[1];
      cyc(1);
    end
    chk(n0, 32'h0000_0003);
    chk(n1, 32'h0000_0003);
    done("test pulses");
    k = {sh, sl};
    {sh, sl} <= ~k;
    cyc(2);
    chk(na, k);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk(na, {sh, sl});
    done("straps");
    conclude();
  end
endmodule
bind sorc_top sorc_checker #(
  .FILT_CYCLES(FILT_CYCLES),
  .EDM_CYCLES(EDM_CYCLES)
) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .system_run_permit_a, .system_run_permit_b, .address_strap_low,
  .address_strap_high, .restart_feedback, .logic_demand,
  .safety_switched_output, .node_address, .system_active
);
`default_nettype wire
